// >>> verilog/nvc_ctrl.sv
// top of the interrupt priority and pending controller
// assumes an Avalon-MM master with privilege and security sidebands,
// interrupt lines from peripherals, and handler events from the core
//
// Behaviour
// RULE_01: one 8-bit priority per interrupt, four per word
// RULE_02: priority words take byte, halfword, word writes
// RULE_03: lower priority value means more urgent
// RULE_04: unimplemented low priority bits read zero
// RULE_05: interrupt M sits in word M/4, lane M%4
// RULE_06: nonsecure priorities follow the shift setting
// RULE_07: secure-only bits hidden from nonsecure; one copy
// RULE_08: clear-pending write one clears, read shows pending
// RULE_09: clear-pending leaves active state alone
// RULE_10: trigger register pends interrupt number in bits 8:0
// RULE_11: unprivileged trigger only with permit; permit privileged
// RULE_12: pulse inputs sampled on rising clock edge
// RULE_13: peripheral holds pulse at least one cycle
// RULE_14: peripheral holds level until serviced
// RULE_15: handler entry clears pending, sets active
// RULE_16: asserted level pends when not active
// RULE_17: rising edge pends a pulse interrupt
// RULE_18: level return re-pends if still asserted
// RULE_19: pulse while active gives active and pending
// RULE_20: level clear ignored while line asserted
// RULE_21: pulse clear drops only pending
// RULE_22: disabled interrupts can still become pending
// RULE_23: master uses aligned accesses only
// RULE_24: set-pending write one pends, zero ignored
// RULE_25: only enabled pending interrupts are offered
// RULE_26: trigger with unimplemented number is ignored
`timescale 1ns/1ps

module nvc_ctrl
   import nvc_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // avalon-mm slave
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [LANES-1:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // access attributes of the current request
   input wire logic avs_priv,
   input wire logic avs_nonsecure,
   // interrupt request lines
   input wire logic [NUM_IRQ-1:0] irq_req,
   // priority-shift setting for nonsecure interrupts
   input wire logic nonsecure_priority_shift,
   // core handler events
   input wire nvc_hdl_s hdl_enter,
   input wire nvc_hdl_s hdl_exit,
   // most urgent enabled pending interrupt
   output nvc_take_s take
);
   // ==========================================================
   // helpers

   // byte enables widened to a bit mask
   function automatic logic [31:0] lane_mask(input logic [LANES-1:0] be);
      logic [31:0] m;
      m = '0;
      for (int l = 0; l < LANES; l++)
         m[8*l +: 8] = {8{be[l]}};
      return m;
   endfunction

   // one-hot of an interrupt number, empty if not implemented
   function automatic logic [NUM_IRQ-1:0] id_hot(input logic ok,
                                                 input logic [ID_W-1:0] id);
      logic [NUM_IRQ-1:0] h;
      h = '0;
      for (int i = 0; i < NUM_IRQ; i++)
         if (ok && id == ID_W'(i))
            h[i] = 1'b1;
      return h;
   endfunction

   // ==========================================================
   // state
   logic wait_reg;
   logic [31:0] rdata_reg, rdata_next;
   logic [NUM_IRQ-1:0] en_reg;
   logic [NUM_IRQ-1:0] tgt_reg;
   logic [NUM_IRQ-1:0] pulse_reg;
   logic permit_reg;
   logic [PRIO_W-1:0] prio_reg [NUM_IRQ];
   logic [PRIO_W-1:0] eff_prio [NUM_IRQ];
   nvc_take_s take_reg, take_next;

   logic acc_wr, acc_rd;
   logic [31:0] wmask, vis;
   logic [ADDR_W-1:0] prio_off;
   logic [ADDR_W-3:0] prio_idx;
   logic in_prio;
   logic [NUM_IRQ-1:0] set_vec, clr_vec, enter_vec, exit_vec, software_interrupt_trigger_vec;
   logic [NUM_IRQ-1:0] pend_vec, act_vec;
   logic software_interrupt_trigger_ok;
   logic [ID_W-1:0] software_interrupt_trigger_id;

   // ==========================================================
   // bus handshake

   // a write is accepted on the edge where waitrequest is seen low, a read on the edge before
   assign acc_wr = avs_write && !wait_reg;
   assign acc_rd = avs_read && wait_reg;
   assign wmask = lane_mask(avs_byteenable);

   // nonsecure masters see only nonsecure-targeted interrupts
   assign vis = avs_nonsecure ? tgt_reg : '1; // RULE_07

   // priority window decode
   assign prio_off = avs_address - OFS_PRIO;
   assign prio_idx = prio_off[ADDR_W-1:2];
   assign in_prio = (avs_address >= OFS_PRIO) &&
                    (prio_idx < (ADDR_W-2)'(NUM_PRIO_REGS)); // RULE_01

   // waitrequest drops for one cycle after a request is seen
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn)
         wait_reg <= 1'b1;
      else
         wait_reg <= !((avs_read || avs_write) && wait_reg);
   end

   // ==========================================================
   // software events to the cells

   // trigger decode, gated by privilege, range and security
   assign software_interrupt_trigger_id = avs_writedata[ID_W-1:0]; // RULE_10
   assign software_interrupt_trigger_ok = acc_wr && avs_address == OFS_SOFTWARE_INTERRUPT_TRIGGER &&
                    avs_byteenable[0] && avs_byteenable[1] &&
                    (avs_priv || permit_reg) && // RULE_11
                    software_interrupt_trigger_id <= SOFTWARE_INTERRUPT_TRIGGER_ID_MAX &&
                    software_interrupt_trigger_id < ID_W'(NUM_IRQ); // RULE_26
   assign software_interrupt_trigger_vec = id_hot(software_interrupt_trigger_ok, software_interrupt_trigger_id) & vis[NUM_IRQ-1:0];

   // set and clear pending strobes
   always_comb begin
      set_vec = software_interrupt_trigger_vec;
      clr_vec = '0;
      if (acc_wr && avs_address == OFS_SET_PEND)
         set_vec = set_vec | (avs_writedata & wmask & vis); // RULE_24
      if (acc_wr && avs_address == OFS_CLR_PEND)
         clr_vec = avs_writedata & wmask & vis; // RULE_08
   end

   // handler entry and return from the core
   assign enter_vec = id_hot(hdl_enter.valid, hdl_enter.id);
   assign exit_vec = id_hot(hdl_exit.valid, hdl_exit.id);

   // ==========================================================
   // per-interrupt cells and priority bytes
   genvar g;
   generate
      for (g = 0; g < NUM_IRQ; g++) begin : gen_irq
         nvc_irq_cell u_cell (
            .clk_sys(clk_sys),
            .rstn(rstn),
            .req_pin(irq_req[g]),
            .is_pulse(pulse_reg[g]),
            .sw_set(set_vec[g]),
            .sw_clr(clr_vec[g]),
            .hdl_enter(enter_vec[g]),
            .hdl_exit(exit_vec[g]),
            .pending(pend_vec[g]),
            .active(act_vec[g])
         );

         // byte lane writes update only the addressed field
         always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn)
               prio_reg[g] <= PRIO_RESET;
            else if (acc_wr && in_prio && prio_idx == (ADDR_W-2)'(g / LANES) &&
                     avs_byteenable[g % LANES] && vis[g]) // RULE_02 RULE_05
               prio_reg[g] <= avs_writedata[8*(g % LANES) +: 8] & PRIO_MASK; // RULE_04
         end

         // nonsecure priorities are folded into the lower half
         assign eff_prio[g] = (tgt_reg[g] && nonsecure_priority_shift) ?
                              (NS_PRIO_TOP | (prio_reg[g] >> 1)) :
                              prio_reg[g]; // RULE_06
      end
   endgenerate

   // ==========================================================
   // control registers

   // enable set and clear
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn)
         en_reg <= '0;
      else if (acc_wr && avs_address == OFS_ENA_SET)
         en_reg <= en_reg | (avs_writedata & wmask & vis);
      else if (acc_wr && avs_address == OFS_ENA_CLR)
         en_reg <= en_reg & ~(avs_writedata & wmask & vis);
   end

   // target state, secure masters only
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn)
         tgt_reg <= '0;
      else if (acc_wr && avs_address == OFS_TARGET && !avs_nonsecure)
         tgt_reg <= (tgt_reg & ~wmask) | (avs_writedata & wmask); // RULE_07
   end

   // line kind, one means pulse
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn)
         pulse_reg <= '0;
      else if (acc_wr && avs_address == OFS_PULSE_CFG)
         pulse_reg <= (pulse_reg & ~(wmask & vis)) | (avs_writedata & wmask & vis);
   end

   // unprivileged trigger permit, privileged writes only
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn)
         permit_reg <= 1'b0;
      else if (acc_wr && avs_address == OFS_CONFIG && avs_priv && avs_byteenable[0])
         permit_reg <= avs_writedata[CFG_PERMIT_BIT]; // RULE_11
   end

   // ==========================================================
   // read path, unmapped reads return zero
   always_comb begin
      rdata_next = WORD_RESET;
      if (avs_address == OFS_ENA_SET || avs_address == OFS_ENA_CLR)
         rdata_next = en_reg & vis;
      else if (avs_address == OFS_SET_PEND || avs_address == OFS_CLR_PEND)
         rdata_next = pend_vec & vis; // RULE_08
      else if (avs_address == OFS_ACTIVE)
         rdata_next = act_vec & vis;
      else if (avs_address == OFS_TARGET)
         rdata_next = avs_nonsecure ? WORD_RESET : tgt_reg;
      else if (avs_address == OFS_PULSE_CFG)
         rdata_next = pulse_reg & vis;
      else if (avs_address == OFS_CONFIG)
         rdata_next[CFG_PERMIT_BIT] = permit_reg;
      else if (in_prio) begin
         for (int l = 0; l < LANES; l++) begin
            if (int'(prio_idx) * LANES + l < NUM_IRQ &&
                vis[int'(prio_idx) * LANES + l])
               rdata_next[8*l +: 8] = prio_reg[int'(prio_idx) * LANES + l]; // RULE_05
         end
      end
   end

   // read data captured as waitrequest drops
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn)
         rdata_reg <= WORD_RESET;
      else if (acc_rd)
         rdata_reg <= rdata_next;
   end

   // ==========================================================
   // arbitration toward the core
   logic arb_found;
   logic [ID_W-1:0] arb_id;
   logic [PRIO_W-1:0] arb_prio;

   nvc_prio_arb u_arb (
      .cand(pend_vec & en_reg), // RULE_25 RULE_22
      .prio(eff_prio),
      .found(arb_found),
      .best_id(arb_id),
      .best_prio(arb_prio)
   );

   // offer register
   always_comb begin
      take_next.valid = arb_found;
      take_next.id = arb_id;
      take_next.prio = arb_prio;
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn)
         take_reg <= '0;
      else
         take_reg <= take_next;
   end

   // ==========================================================
   // outputs
   assign avs_readdata = rdata_reg;
   assign avs_waitrequest = wait_reg;
   assign take = take_reg;
endmodule

// >>> verilog/nvc_pkg.sv
// shared constants and carrier types for the interrupt priority/pending block
// assumes one 250 MHz system clock and a 32-bit Avalon-MM register port

package nvc_pkg;
   // ==========================================================
   // sizes
   localparam int NUM_IRQ = 32;
   localparam int ID_W = 9;
   localparam int PRIO_W = 8;
   localparam int LANES = 4;
   localparam int NUM_PRIO_REGS = 120;
   localparam int ADDR_W = 12;
   localparam int CLK_MHZ = 250;
   // implemented priority bits are the upper ones, low ones read zero
   localparam logic [PRIO_W-1:0] PRIO_MASK = 8'hF0;
   localparam logic [PRIO_W-1:0] PRIO_RESET = 8'h00;
   localparam logic [PRIO_W-1:0] NS_PRIO_TOP = 8'h80;
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;
   localparam logic [ID_W-1:0] SOFTWARE_INTERRUPT_TRIGGER_ID_MAX = 9'h1DF;

   // ==========================================================
   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_ENA_SET = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_ENA_CLR = 12'h080;
   localparam logic [ADDR_W-1:0] OFS_SET_PEND = 12'h100;
   localparam logic [ADDR_W-1:0] OFS_CLR_PEND = 12'h180;
   localparam logic [ADDR_W-1:0] OFS_ACTIVE = 12'h200;
   localparam logic [ADDR_W-1:0] OFS_TARGET = 12'h280;
   localparam logic [ADDR_W-1:0] OFS_PULSE_CFG = 12'h2C0;
   localparam logic [ADDR_W-1:0] OFS_PRIO = 12'h300;
   localparam logic [ADDR_W-1:0] OFS_CONFIG = 12'h500;
   localparam logic [ADDR_W-1:0] OFS_SOFTWARE_INTERRUPT_TRIGGER = 12'h600;
   localparam int CFG_PERMIT_BIT = 0;

   // ==========================================================
   // per-interrupt state, codes are {active, pending}
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_PEND = 2'b01,
      ST_ACT = 2'b10,
      ST_ACT_PEND = 2'b11
   } nvc_irq_state_e;

   // core handler entry or return event
   typedef struct packed {
      logic valid;
      logic [ID_W-1:0] id;
   } nvc_hdl_s;

   // best candidate offered to the core
   typedef struct packed {
      logic valid;
      logic [ID_W-1:0] id;
      logic [PRIO_W-1:0] prio;
   } nvc_take_s;
endpackage

// >>> verilog/nvc_irq_cell.sv
// one interrupt's pending/active state and its request input path
// assumes req_pin is asynchronous to clk_sys; all other inputs are on clk_sys
`timescale 1ns/1ps

module nvc_irq_cell
   import nvc_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // request line and its kind
   input wire logic req_pin,
   input wire logic is_pulse,
   // software and core events
   input wire logic sw_set,
   input wire logic sw_clr,
   input wire logic hdl_enter,
   input wire logic hdl_exit,
   // state
   output logic pending,
   output logic active
);
   // ==========================================================
   // input sampling
   logic req_s1_reg, req_s2_reg, req_s3_reg;
   nvc_irq_state_e state_reg, state_next;
   logic pend_n, act_n, rise;

   // two-stage synchroniser plus edge history
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         req_s1_reg <= 1'b0;
         req_s2_reg <= 1'b0;
         req_s3_reg <= 1'b0;
      end else begin
         req_s1_reg <= req_pin;
         req_s2_reg <= req_s1_reg;
         req_s3_reg <= req_s2_reg; // RULE_12
      end
   end

   assign rise = req_s2_reg && !req_s3_reg;

   // ==========================================================
   // state update
   always_comb begin
      case (state_reg)
         ST_IDLE: begin
            pending = 1'b0;
            active = 1'b0;
         end
         ST_PEND: begin
            pending = 1'b1;
            active = 1'b0;
         end
         ST_ACT: begin
            pending = 1'b0;
            active = 1'b1;
         end
         ST_ACT_PEND: begin
            pending = 1'b1;
            active = 1'b1;
         end
         default: begin
            pending = 1'b0;
            active = 1'b0;
         end
      endcase
      pend_n = pending;
      act_n = active;
      // level clear has no effect while the line is high
      if (sw_clr && (is_pulse || !req_s2_reg))
         pend_n = 1'b0; // RULE_20 RULE_21 RULE_09
      if (hdl_enter) begin
         pend_n = 1'b0; // RULE_15
         act_n = 1'b1;
      end
      if (hdl_exit) begin
         act_n = 1'b0;
         if (!is_pulse)
            pend_n = req_s2_reg; // RULE_18
      end
      // sets come last so they win over any clear
      if (!is_pulse && req_s2_reg && !active && !hdl_enter)
         pend_n = 1'b1; // RULE_16 RULE_22
      if (is_pulse && rise)
         pend_n = 1'b1; // RULE_17 RULE_19
      if (sw_set)
         pend_n = 1'b1; // RULE_24
      state_next = nvc_irq_state_e'({act_n, pend_n});
   end

   // state register
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn)
         state_reg <= ST_IDLE;
      else
         state_reg <= state_next;
   end
endmodule

// >>> verilog/nvc_prio_arb.sv
// picks the most urgent candidate interrupt
// assumes priorities are already adjusted for the nonsecure shift
`timescale 1ns/1ps

module nvc_prio_arb
   import nvc_pkg::*;
(
   // candidates and their priorities
   input wire logic [NUM_IRQ-1:0] cand,
   input wire logic [PRIO_W-1:0] prio [NUM_IRQ],
   // winner
   output logic found,
   output logic [ID_W-1:0] best_id,
   output logic [PRIO_W-1:0] best_prio
);
   // ==========================================================
   // lowest value wins, lowest number breaks ties
   always_comb begin
      found = 1'b0;
      best_id = '0;
      best_prio = '1;
      for (int i = 0; i < NUM_IRQ; i++) begin
         if (cand[i] && (!found || prio[i] < best_prio)) begin // RULE_03
            found = 1'b1;
            best_id = ID_W'(i);
            best_prio = prio[i];
         end
      end
   end
endmodule

// >>> tb/nvc_checker.sv
// port checks for the priority/pending controller
// assumes one clock; bound to nvc_ctrl below
`timescale 1ns/1ps

module nvc_checker
   import nvc_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // bus and core side
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [NUM_IRQ-1:0] irq_req,
   input wire nvc_hdl_s hdl_enter,
   input wire nvc_take_s take
);
   // ==========================================================
   // assertions
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   logic rd_done;
   // a read answered in this cycle
   assign rd_done = avs_read && !avs_waitrequest;
   a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered");
   a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   a_wait_idle: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
      else $error("answer without request");
   a_wait_reset: assert property ($rose(rstn) |-> avs_waitrequest)
      else $error("waitrequest low at release");
   a_rdata_hold: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
      else $error("readdata moved");
   a_unmapped_zero: assert property (rd_done && avs_address >= 12'h700 |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   a_prio_low: assert property (rd_done && avs_address >= OFS_PRIO && avs_address < OFS_CONFIG
      |-> (avs_readdata & 32'h0F0F0F0F) == 32'h0)
      else $error("low priority bits set");
   a_take_range: assert property (take.valid |-> take.id < NUM_IRQ)
      else $error("offered id out of range");
   a_enter_clear: assert property (hdl_enter.valid && !irq_req[hdl_enter.id[4:0]]
      |-> ##2 !(take.valid && take.id == $past(hdl_enter.id, 2)))
      else $error("entered interrupt still offered");
   c_read_done: cover property (rd_done);
   c_take: cover property (take.valid);
   c_enter: cover property (hdl_enter.valid);
endmodule

bind nvc_ctrl nvc_checker u_chk (.clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .irq_req(irq_req), .hdl_enter(hdl_enter), .take(take));

// >>> tb/nvc_core_model.sv
// stand-in for the core and the peripherals
// assumes the bench calls its tasks; drives follow the rising edge
`timescale 1ns/1ps

module nvc_core_model
   import nvc_pkg::*;
(
   // clock
   input wire logic clk_sys,
   // request lines and handler events
   output logic [NUM_IRQ-1:0] irq_req,
   output nvc_hdl_s hdl_enter,
   output nvc_hdl_s hdl_exit
);
   // ==========================================================
   // drivers
   initial begin
      irq_req = '0;
      hdl_enter = '0;
      hdl_exit = '0;
   end
   // level line held until service is done
   task automatic level(input int n, input logic v);
      @(posedge clk_sys);
      irq_req[n] <= v;
   endtask
   // pulse line high one whole cycle
   task automatic pulse(input int n);
      @(posedge clk_sys);
      irq_req[n] <= 1'b1;
      @(posedge clk_sys);
      irq_req[n] <= 1'b0;
   endtask
   // handler entry or return after dly idle cycles
   task automatic hdl(input logic ex, input int id, input int dly);
      repeat (dly) @(posedge clk_sys);
      @(posedge clk_sys);
      if (ex) begin
         hdl_exit <= {1'b1, id[ID_W-1:0]};
      end else begin
         hdl_enter <= {1'b1, id[ID_W-1:0]};
      end
      @(posedge clk_sys);
      hdl_enter <= '0;
      hdl_exit <= '0;
   endtask
endmodule

// >>> tb/tb_nvc_ctrl.sv
// self-checking bench for the priority/pending controller
// assumes the core model and the bound checker are compiled
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end

module tb_nvc_ctrl
   import nvc_pkg::*;
   ;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic [ADDR_W-1:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = '0;
   logic [LANES-1:0] avs_byteenable = '0;
   logic avs_priv = 1'b0;
   logic avs_nonsecure = 1'b0;
   logic nonsecure_priority_shift = 1'b0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [NUM_IRQ-1:0] irq_req;
   nvc_hdl_s hdl_enter;
   nvc_hdl_s hdl_exit;
   nvc_take_s take;
   int mismatches = 0;
   int tests_run = 0;
   int cycles = 0;
   logic [31:0] seed = 32'h0000_0021;
   logic [31:0] rv;
   logic [31:0] exp_v;
   logic [31:0] exp_q [$];

   // ==========================================================
   // clock, parts and checking
   always #2 clk_sys = ~clk_sys;
   nvc_ctrl dut (.clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .avs_priv(avs_priv), .avs_nonsecure(avs_nonsecure),
      .irq_req(irq_req), .nonsecure_priority_shift(nonsecure_priority_shift),
      .hdl_enter(hdl_enter), .hdl_exit(hdl_exit), .take(take));
   nvc_core_model u_core (.clk_sys(clk_sys), .irq_req(irq_req), .hdl_enter(hdl_enter),
      .hdl_exit(hdl_exit));
   // read answers against the oldest note
   always @(posedge clk_sys) begin
      if (rstn && avs_read && avs_waitrequest === 1'b0) begin
         exp_v = exp_q.pop_front();
         `CHK(avs_readdata, exp_v)
      end
   end
   // hang guard
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         conclude();
      end
   end
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // one avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
      input logic [3:0] be, input logic p, input logic ns);
      @(posedge clk_sys);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_priv <= p;
      avs_nonsecure <= ns;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
      input logic [3:0] be = 4'hF);
      bus(1'b1, a, d, be, 1'b1, 1'b0);
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e,
      input logic ns = 1'b0);
      exp_q.push_back(e);
      bus(1'b0, a, 32'h0, 4'hF, 1'b1, ns);
   endtask

   // ==========================================================
   // main sequence
   initial begin
      repeat (5) @(posedge clk_sys);
      rstn <= 1'b1;
      rd(OFS_PRIO, 32'h0);
      rd(OFS_ACTIVE, 32'h0);
      wr(OFS_PRIO, 32'hFFFFFFFF);
      rd(OFS_PRIO, 32'hF0F0F0F0);
      wr(OFS_PRIO, 32'h00005500, 4'h2);
      rd(OFS_PRIO, 32'hF0F050F0);
      wr(OFS_PRIO, 32'h12340000, 4'hC);
      rd(OFS_PRIO, 32'h103050F0);
      for (int i = 5; i < 8; i += 2) begin
         rv = xs();
         wr(OFS_PRIO + 12'(4 * i), rv);
         rd(OFS_PRIO + 12'(4 * i), rv & 32'hF0F0F0F0);
      end
      wr(12'h7FC, 32'hFFFFFFFF);
      rd(12'h7FC, 32'h0);
      // software trigger, range and permission
      wr(OFS_SOFTWARE_INTERRUPT_TRIGGER, 32'h3);
      wr(OFS_SOFTWARE_INTERRUPT_TRIGGER, 32'h28);
      wr(OFS_SOFTWARE_INTERRUPT_TRIGGER, 32'h1DF);
      bus(1'b1, OFS_SOFTWARE_INTERRUPT_TRIGGER, 32'h4, 4'hF, 1'b0, 1'b0);
      bus(1'b1, OFS_CONFIG, 32'h1, 4'hF, 1'b0, 1'b0);
      bus(1'b1, OFS_SOFTWARE_INTERRUPT_TRIGGER, 32'h4, 4'hF, 1'b0, 1'b0);
      rd(OFS_CLR_PEND, 32'h8);
      rd(OFS_CLR_PEND, 32'h0, 1'b1);
      wr(OFS_CONFIG, 32'h1);
      bus(1'b1, OFS_SOFTWARE_INTERRUPT_TRIGGER, 32'h5, 4'hF, 1'b0, 1'b0);
      rd(OFS_CLR_PEND, 32'h28);
      wr(OFS_CLR_PEND, 32'h20);
      rd(OFS_CLR_PEND, 32'h8);
      wr(OFS_CLR_PEND, 32'h8);
      rd(OFS_CLR_PEND, 32'h0);
      // pending while disabled, then arbitration
      wr(OFS_SET_PEND, 32'hC0);
      wr(OFS_PRIO + 12'h004, 32'h40800000);
      rd(OFS_CLR_PEND, 32'hC0);
      `CHK(take.valid, 1'b0)
      wr(OFS_ENA_SET, 32'hC0);
      wr(OFS_SET_PEND, 32'hC0);
      repeat (3) @(posedge clk_sys);
      `CHK(take, {1'b1, 9'h007, 8'h40})
      u_core.hdl(1'b0, 7, 0);
      repeat (2) @(posedge clk_sys);
      `CHK(take.id, 9'h006)
      rd(OFS_ACTIVE, 32'h80);
      wr(OFS_CLR_PEND, 32'hC0);
      rd(OFS_ACTIVE, 32'h80);
      u_core.hdl(1'b1, 7, 2);
      rd(OFS_ACTIVE, 32'h0);
      // level line
      u_core.level(8, 1'b1);
      repeat (4) @(posedge clk_sys);
      rd(OFS_CLR_PEND, 32'h100);
      u_core.hdl(1'b0, 8, 0);
      rd(OFS_CLR_PEND, 32'h0);
      u_core.hdl(1'b1, 8, 0);
      rd(OFS_CLR_PEND, 32'h100);
      wr(OFS_CLR_PEND, 32'h100);
      rd(OFS_CLR_PEND, 32'h100);
      u_core.level(8, 1'b0);
      repeat (4) @(posedge clk_sys);
      wr(OFS_CLR_PEND, 32'h100);
      rd(OFS_CLR_PEND, 32'h0);
      // pulse line
      wr(OFS_PULSE_CFG, 32'h200);
      u_core.pulse(9);
      repeat (4) @(posedge clk_sys);
      rd(OFS_CLR_PEND, 32'h200);
      u_core.hdl(1'b0, 9, 3);
      u_core.pulse(9);
      repeat (4) @(posedge clk_sys);
      rd(OFS_CLR_PEND, 32'h200);
      wr(OFS_CLR_PEND, 32'h200);
      rd(OFS_ACTIVE, 32'h200);
      rd(OFS_CLR_PEND, 32'h0);
      u_core.pulse(9);
      repeat (4) @(posedge clk_sys);
      u_core.hdl(1'b1, 9, 0);
      rd(OFS_ACTIVE, 32'h0);
      rd(OFS_CLR_PEND, 32'h200);
      wr(OFS_CLR_PEND, 32'h200);
      rd(OFS_CLR_PEND, 32'h0);
      // nonsecure target with shifted priority
      wr(OFS_TARGET, 32'h40);
      nonsecure_priority_shift <= 1'b1;
      wr(OFS_SET_PEND, 32'h40);
      repeat (3) @(posedge clk_sys);
      `CHK(take, {1'b1, 9'h006, 8'hC0})
      rd(OFS_PRIO + 12'h004, 32'h00800000, 1'b1);
      // nonsecure write reaches only its own lane
      bus(1'b1, OFS_PRIO + 12'h004, 32'hFFFFFFFF, 4'hF, 1'b1, 1'b1);
      rd(OFS_PRIO + 12'h004, 32'h40F00000);
      // disable keeps pending but stops the offer
      wr(OFS_ENA_CLR, 32'h40);
      repeat (3) @(posedge clk_sys);
      `CHK(take.valid, 1'b0)
      rd(OFS_CLR_PEND, 32'h40);
      repeat (2) @(posedge clk_sys);
      conclude();
   end
endmodule
